// file: shared/mshbc_defs.svh
// offsets, field positions, reset values for the stop, hold and blend supervisor
`ifndef MSHBC_DEFS_SVH
`define MSHBC_DEFS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define MSHBC_CTRL_OFS      12'h000
`define MSHBC_RAMP_OFS      12'h004
`define MSHBC_IDXVLD_OFS    12'h008
`define MSHBC_IDXSYN_OFS    12'h00C
`define MSHBC_STAT_OFS      12'h010
// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define MSHBC_C_STOP        0
`define MSHBC_C_HALT        1
`define MSHBC_C_HOLD        2
`define MSHBC_C_LHOLD       4
`define MSHBC_C_LHALT       6
`define MSHBC_C_STOPCLR     8
// ---------------------------------------------------------------
// reset values and widths
// ---------------------------------------------------------------
`define MSHBC_CTRL_RST      9'h000
`define MSHBC_RAMP_RST      16'h0100
`define MSHBC_IDX_RST       16'h0000
`define MSHBC_SYNC_W        7
`endif

// file: shared/mshbc_pkg.sv
// types for the stop, hold and blend supervisor
`default_nettype none
package mshbc_pkg;
    // sequencer instruction codes
    typedef enum logic [3:0] {
        MSHBC_OP_NOP       = 4'h0,
        MSHBC_OP_INDEX     = 4'h1,
        MSHBC_OP_CHAIN     = 4'h2,
        MSHBC_OP_BLEND     = 4'h3,
        MSHBC_OP_GEAR_ON   = 4'h4,
        MSHBC_OP_GEAR_OFF  = 4'h5,
        MSHBC_OP_JOG_STOP  = 4'h6,
        MSHBC_OP_LANE_STOP = 4'h7,
        MSHBC_OP_HOLD_ON   = 4'h8,
        MSHBC_OP_HOLD_OFF  = 4'h9,
        MSHBC_OP_LHOLD_ON  = 4'hA,
        MSHBC_OP_LHOLD_OFF = 4'hB,
        MSHBC_OP_STOP_ON   = 4'hC
    } mshbc_op_e;
    // kind of chained start
    typedef enum logic [1:0] {
        MSHBC_CH_NONE  = 2'h0,
        MSHBC_CH_CHAIN = 2'h1,
        MSHBC_CH_BLEND = 2'h2
    } mshbc_chain_e;
endpackage : mshbc_pkg
`default_nettype wire

// file: src/mshbc_top.sv
// stop, hold, blend and gear supervisor with apb registers
`timescale 1ns/1ps
`default_nettype none
`include "mshbc_defs.svh"
// Summary of operation
// - blend target from constant or variable
// - missing or mismatched target becomes compound
// - blend ignores target direction
// - blend uses own decel toward next
// - compound uses next index accel ramp
// - program gear runs until block, or until gear stop or program end in a cycle with no lane blocked
// - program end stops its gear when no lane block lands in the same cycle
// - gear start while geared stalls until that lane's gear stops
// - global stop halts all, kills programs
// - all-motion halt blocks motion, programs run
// - hold freezes profile time, not gear
// - motion flags keep values during hold
// - hold ramp symmetric down and up
// - motion instruction waits during hold
// - lane hold affects selected lane only
// - lane motion halt affects selected lane
// - jog stop on given lane only
// - gear stop while idle just advances
// - program hold stays until written off
// - lane stop pulse does not block
module mshbc_top
    import mshbc_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // assignment pins
    input  wire logic        stop_i,
    input  wire logic        all_motion_halt_i,
    input  wire logic        hold_i,
    input  wire logic [1:0]  lane_hold_i,
    input  wire logic [1:0]  lane_motion_halt_i,
    // program sequencer
    input  wire logic        instr_valid_i,
    input  wire logic [3:0]  instr_op_i,
    input  wire logic        instr_lane_i,
    input  wire logic [3:0]  instr_idx_i,
    input  wire logic [3:0]  instr_tgt_i,
    input  wire logic        instr_tgt_var_i,
    input  wire logic [3:0]  instr_var_i,
    input  wire logic        prog_end_i,
    output logic             instr_done_o,
    output logic             prog_kill_o,
    // profile generator
    input  wire logic [1:0]  gen_in_prog_i,
    input  wire logic [1:0]  gen_cruise_i,
    output logic [1:0]       move_in_progress_flag_o,
    output logic [1:0]       move_cruise_flag_o,
    output logic [1:0]       lane_halt_o,
    output logic [1:0]       lane_block_o,
    output logic [31:0]      lane_rate_o,
    output logic [1:0]       gear_run_o,
    output logic [1:0]       jog_stop_o,
    output logic             start_o,
    output logic [3:0]       start_idx_o,
    output logic             start_lane_o,
    output logic [1:0]       chain_kind_o,
    output logic [3:0]       chain_tgt_o,
    output logic             ramp_next_accel_o,
    output logic             dir_ignore_o
);
    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    logic [`MSHBC_SYNC_W-1:0] sync1_r;
    logic [`MSHBC_SYNC_W-1:0] sync2_r;
    logic [8:0]               ctrl_r;
    logic [15:0]              ramp_r;
    logic [15:0]              idx_vld_r;
    logic [15:0]              idx_syn_r;
    logic                     stop_lat_r;
    logic                     hold_lat_r;
    logic [1:0]               lhold_lat_r;
    logic [1:0]               gear_prog_r;
    logic                     stop_eff;
    logic                     halt_eff;
    logic [1:0]               lhalt_eff;
    logic [1:0]               block;
    logic [1:0]               held;
    logic                     take;
    logic                     motion_op;
    logic                     stall;
    logic                     apb_wr;
    logic                     clr_stop;
    logic [3:0]               tgt;
    mshbc_op_e                op;

    // blend target usable: exists and same time base
    function automatic logic blend_ok(input logic [3:0] t, input logic [3:0] c, input logic [15:0] v,
                                      input logic [15:0] s);
        blend_ok = v[t] & (s[t] == s[c]);
    endfunction : blend_ok

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {lane_motion_halt_i, lane_hold_i, hold_i, all_motion_halt_i, stop_i};
            sync2_r <= sync1_r;
        end
    end

    // ---------------------------------------------------------------
    // stop and hold resolution
    // ---------------------------------------------------------------
    assign op        = mshbc_op_e'(instr_op_i);
    assign stop_eff  = sync2_r[0] | ctrl_r[`MSHBC_C_STOP] | stop_lat_r;
    assign halt_eff  = sync2_r[1] | ctrl_r[`MSHBC_C_HALT];
    assign lhalt_eff = sync2_r[6:5] | ctrl_r[`MSHBC_C_LHALT+1:`MSHBC_C_LHALT];
    assign block     = {2{stop_eff | halt_eff}} | lhalt_eff;
    assign held      = ({2{sync2_r[2] | ctrl_r[`MSHBC_C_HOLD] | hold_lat_r}}
                       | sync2_r[4:3] | ctrl_r[`MSHBC_C_LHOLD+1:`MSHBC_C_LHOLD]
                       | lhold_lat_r) & ~block;
    assign take      = instr_valid_i & ~instr_done_o;
    assign motion_op = (op == MSHBC_OP_INDEX) | (op == MSHBC_OP_CHAIN)
                     | (op == MSHBC_OP_BLEND) | (op == MSHBC_OP_GEAR_ON);
    assign stall     = (motion_op & (held[instr_lane_i] | block[instr_lane_i]))
                     | ((op == MSHBC_OP_GEAR_ON) & gear_run_o[instr_lane_i]);
    assign tgt       = instr_tgt_var_i ? instr_var_i : instr_tgt_i;
    assign apb_wr    = psel_i & penable_i & pready_o & pwrite_i;
    assign clr_stop  = apb_wr & (paddr_i == `MSHBC_CTRL_OFS) & pwdata_i[`MSHBC_C_STOPCLR];

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            lane_block_o <= '0;
            lane_halt_o  <= '0;
            prog_kill_o  <= 1'b0;
        end else begin
            lane_block_o <= block;
            prog_kill_o  <= stop_eff;
            lane_halt_o  <= block;
            if (take & (op == MSHBC_OP_LANE_STOP)) begin
                lane_halt_o[instr_lane_i] <= 1'b1;
            end
        end
    end

    // program stop latch; set wins, cleared only from the bus
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            stop_lat_r <= 1'b0;
        end else if (take & (op == MSHBC_OP_STOP_ON)) begin
            stop_lat_r <= 1'b1;
        end else if (clr_stop) begin
            stop_lat_r <= 1'b0;
        end
    end

    // program hold latches
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            hold_lat_r  <= 1'b0;
            lhold_lat_r <= '0;
        end else if (take) begin
            if (op == MSHBC_OP_HOLD_ON) begin
                hold_lat_r <= 1'b1;
            end
            if (op == MSHBC_OP_HOLD_OFF) begin
                hold_lat_r <= 1'b0;
            end
            if (op == MSHBC_OP_LHOLD_ON) begin
                lhold_lat_r[instr_lane_i] <= 1'b1;
            end
            if (op == MSHBC_OP_LHOLD_OFF) begin
                lhold_lat_r[instr_lane_i] <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // hold time rate per lane
    // ---------------------------------------------------------------
    for (genvar l = 0; l < 2; l++) begin : g_rate
        always_ff @(posedge core_clk_i) begin
            if (reset_i) begin
                lane_rate_o[16*l+:16] <= `MSHBC_RAMP_RST;
            end else if (lane_rate_o[16*l+:16] > ramp_r) begin
                lane_rate_o[16*l+:16] <= ramp_r;
            end else if (held[l] & (lane_rate_o[16*l+:16] != 16'h0000)) begin
                lane_rate_o[16*l+:16] <= lane_rate_o[16*l+:16] - 16'h0001;
            end else if (~held[l] & (lane_rate_o[16*l+:16] != ramp_r)) begin
                lane_rate_o[16*l+:16] <= lane_rate_o[16*l+:16] + 16'h0001;
            end
        end
    end

    // profile flags pass unchanged while time is frozen
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            move_in_progress_flag_o <= '0;
            move_cruise_flag_o      <= '0;
        end else begin
            move_in_progress_flag_o <= gen_in_prog_i;
            move_cruise_flag_o      <= gen_cruise_i;
        end
    end

    // ---------------------------------------------------------------
    // instruction handling
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            instr_done_o      <= 1'b0;
            start_o           <= 1'b0;
            start_idx_o       <= '0;
            start_lane_o      <= 1'b0;
            chain_kind_o      <= MSHBC_CH_NONE;
            chain_tgt_o       <= '0;
            ramp_next_accel_o <= 1'b0;
            dir_ignore_o      <= 1'b0;
            jog_stop_o        <= '0;
        end else begin
            instr_done_o <= take & ~stall;
            start_o      <= 1'b0;
            jog_stop_o   <= '0;
            if (take & ~stall & (op == MSHBC_OP_INDEX | op == MSHBC_OP_CHAIN | op == MSHBC_OP_BLEND)) begin
                start_o           <= 1'b1;
                start_idx_o       <= instr_idx_i;
                start_lane_o      <= instr_lane_i;
                chain_tgt_o       <= tgt;
                chain_kind_o      <= MSHBC_CH_NONE;
                ramp_next_accel_o <= 1'b0;
                dir_ignore_o      <= 1'b0;
                if (op == MSHBC_OP_CHAIN
                    | (op == MSHBC_OP_BLEND & ~blend_ok(tgt, instr_idx_i, idx_vld_r, idx_syn_r))) begin
                    chain_kind_o      <= MSHBC_CH_CHAIN;
                    ramp_next_accel_o <= 1'b1;
                end else if (op == MSHBC_OP_BLEND) begin
                    chain_kind_o <= MSHBC_CH_BLEND;
                    dir_ignore_o <= 1'b1;
                end
            end
            if (take & (op == MSHBC_OP_JOG_STOP)) begin
                jog_stop_o[instr_lane_i] <= 1'b1;
            end
        end
    end

    // gear run per lane
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            gear_run_o  <= '0;
            gear_prog_r <= '0;
        end else begin
            if (take & ~stall & (op == MSHBC_OP_GEAR_ON)) begin
                gear_run_o[instr_lane_i]  <= 1'b1;
                gear_prog_r[instr_lane_i] <= 1'b1;
            end
            if (take & (op == MSHBC_OP_GEAR_OFF)) begin
                gear_run_o[instr_lane_i]  <= 1'b0;
                gear_prog_r[instr_lane_i] <= 1'b0;
            end
            if (prog_end_i) begin
                gear_run_o  <= gear_run_o & ~gear_prog_r;
                gear_prog_r <= '0;
            end
            if (block != 2'b00) begin
                gear_run_o  <= gear_run_o & ~block;
                gear_prog_r <= gear_prog_r & ~block;
            end
        end
    end

    // ---------------------------------------------------------------
    // apb registers
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
        end else begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
            if (psel_i & penable_i & ~pready_o) begin
                unique case (paddr_i)
                    `MSHBC_CTRL_OFS:   prdata_o <= {24'h000000, ctrl_r[7:0]};
                    `MSHBC_RAMP_OFS:   prdata_o <= {16'h0000, ramp_r};
                    `MSHBC_IDXVLD_OFS: prdata_o <= {16'h0000, idx_vld_r};
                    `MSHBC_IDXSYN_OFS: prdata_o <= {16'h0000, idx_syn_r};
                    `MSHBC_STAT_OFS:   prdata_o <= {18'h00000, gear_run_o, held, block,
                                                    lhold_lat_r, hold_lat_r, stop_lat_r,
                                                    halt_eff, stop_eff, 2'h0};
                    default:           pslverr_o <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ctrl_r    <= `MSHBC_CTRL_RST;
            ramp_r    <= `MSHBC_RAMP_RST;
            idx_vld_r <= `MSHBC_IDX_RST;
            idx_syn_r <= `MSHBC_IDX_RST;
        end else if (apb_wr) begin
            if (paddr_i == `MSHBC_CTRL_OFS) begin
                ctrl_r <= {1'b0, pwdata_i[7:0]};
            end
            if (paddr_i == `MSHBC_RAMP_OFS) begin
                ramp_r <= pwdata_i[15:0];
            end
            if (paddr_i == `MSHBC_IDXVLD_OFS) begin
                idx_vld_r <= pwdata_i[15:0];
            end
            if (paddr_i == `MSHBC_IDXSYN_OFS) begin
                idx_syn_r <= pwdata_i[15:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    stop_blocks_all_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        stop_eff |=> (lane_block_o == 2'b11) && prog_kill_o)
        else $error("global stop did not block and kill");
    halt_spares_prog_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        halt_eff && !stop_eff |=> (lane_block_o == 2'b11) && !prog_kill_o)
        else $error("motion halt wrong effect");
    hold_ramp_down_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        held[0] && lane_rate_o[15:0] != 16'h0000 && lane_rate_o[15:0] <= ramp_r
        |=> lane_rate_o[15:0] == $past(lane_rate_o[15:0]) - 16'h0001)
        else $error("hold rate not falling");
    hold_ramp_up_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !held[1] && lane_rate_o[31:16] < ramp_r |=> lane_rate_o[31:16] == $past(lane_rate_o[31:16]) + 16'h0001)
        else $error("release rate not rising");
    gear_restart_stall_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        take && op == MSHBC_OP_GEAR_ON && gear_run_o[instr_lane_i] |=> !instr_done_o)
        else $error("second gear start advanced");
    gear_stop_idle_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        take && op == MSHBC_OP_GEAR_OFF && !gear_run_o[instr_lane_i] |=> instr_done_o)
        else $error("idle gear stop not advanced");
    prog_end_gear_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        prog_end_i && gear_prog_r[0] |=> !gear_run_o[0])
        else $error("gear outlived its program");
    blend_fallback_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        take && !stall && op == MSHBC_OP_BLEND && !idx_vld_r[tgt]
        |=> start_o && chain_kind_o == MSHBC_CH_CHAIN && ramp_next_accel_o)
        else $error("bad blend not chained");
    hold_motion_wait_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        take && motion_op && held[instr_lane_i] |=> !instr_done_o && !start_o)
        else $error("motion ran during hold");
    hold_latch_keep_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        hold_lat_r && !(take && op == MSHBC_OP_HOLD_OFF) |=> hold_lat_r)
        else $error("program hold dropped");
    lane_stop_free_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        take && op == MSHBC_OP_LANE_STOP && !block[instr_lane_i]
        |=> lane_halt_o[instr_lane_i] && !lane_block_o[instr_lane_i])
        else $error("lane stop pulse wrong");
endmodule : mshbc_top
`default_nettype wire

// file: verif/mshbc_gen_model.sv
// profile generator and motor stand-in for the supervisor bench
`timescale 1ns/1ps
`default_nettype none
module mshbc_gen_model (
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    // commands from the supervisor
    input  wire logic       start_i,
    input  wire logic       start_lane_i,
    input  wire logic [1:0] halt_i,
    input  wire logic [1:0] block_i,
    // profile flags back
    output logic      [1:0] in_prog_o,
    output logic      [1:0] cruise_o
);
    // a frozen profile stays active, only a lane halt or block ends it
    always_ff @(posedge core_clk_i) begin
        for (int l = 0; l < 2; l++) begin
            if (reset_i || halt_i[l] || block_i[l]) begin
                in_prog_o[l] <= 1'b0;
            end else if (start_i && start_lane_i == l[0]) begin
                in_prog_o[l] <= 1'b1;
            end
        end
    end
    always_ff @(posedge core_clk_i) begin
        cruise_o <= reset_i ? 2'b00 : in_prog_o & ~halt_i;
    end
endmodule : mshbc_gen_model
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the stop, hold and blend supervisor
`timescale 1ns/1ps
`default_nettype none
`include "mshbc_defs.svh"
module tb_top;
    import mshbc_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, stop = 1'b0, halt = 1'b0, hold = 1'b0;
    logic        ivld = 1'b0, ilane = 1'b0, tvar = 1'b0, pend = 1'b0, ok;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rate;
    logic        pready, pslverr, done, kill, sl, ramp_nx, diri, st;
    logic [1:0]  lhold = 2'h0, lmh = 2'h0, jseen = 2'h0, hseen = 2'h0;
    logic [1:0]  gip, gcr, mip, mcr, lhalt, lblk, gear, jog, ck;
    logic [3:0]  iop = 4'h0, iidx = 4'h0, itgt = 4'h0, ivar = 4'h0, sidx, ctgt, rnd;
    logic [39:0] exp_q[$];
    int          err_total = 0;
    int          n_tests = 0;
    int          seed = 74;
    int          cyc = 0;
    int          st_cnt = 0;

    always #2 core_clk_i = ~core_clk_i;

    mshbc_top mshbc_top_inst (.core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .stop_i(stop), .all_motion_halt_i(halt), .hold_i(hold), .lane_hold_i(lhold),
        .lane_motion_halt_i(lmh), .instr_valid_i(ivld), .instr_op_i(iop), .instr_lane_i(ilane),
        .instr_idx_i(iidx), .instr_tgt_i(itgt), .instr_tgt_var_i(tvar), .instr_var_i(ivar),
        .prog_end_i(pend), .instr_done_o(done), .prog_kill_o(kill), .gen_in_prog_i(gip), .gen_cruise_i(gcr),
        .move_in_progress_flag_o(mip), .move_cruise_flag_o(mcr), .lane_halt_o(lhalt), .lane_block_o(lblk),
        .lane_rate_o(rate), .gear_run_o(gear), .jog_stop_o(jog), .start_o(st), .start_idx_o(sidx),
        .start_lane_o(sl), .chain_kind_o(ck), .chain_tgt_o(ctgt), .ramp_next_accel_o(ramp_nx),
        .dir_ignore_o(diri));

    mshbc_gen_model mshbc_gen_model_inst (.core_clk_i(core_clk_i), .reset_i(reset_i), .start_i(st),
        .start_lane_i(sl), .halt_i(lhalt), .block_i(lblk), .in_prog_o(gip), .cruise_o(gcr));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tdone(input string s);
        $display("test %s done", s);
    endtask : tdone

    // watcher: read answers against queued notes, sticky pulse capture, timeout
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        jseen <= jseen | jog;
        hseen <= hseen | lhalt;
        if (st === 1'b1) begin
            st_cnt <= st_cnt + 1;
        end
        if (psel && pen && pready === 1'b1 && !pwr) begin
            chk({pslverr, prdata}, exp_q.size() > 0 ? exp_q.pop_front() : 40'hFF_FFFF_FFFF);
        end
        if (cyc == 5000) begin
            err_total++;
            conclude();
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk_i);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [39:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // tv set: the target travels as a variable and the constant field holds junk
    task automatic ins(input logic [3:0] op, input logic ln, input logic [3:0] idx, input logic [3:0] tgt,
                       input logic tv, output logic dn);
        int n;
        @(posedge core_clk_i);
        ivld <= 1'b1;
        iop <= op;
        ilane <= ln;
        iidx <= idx;
        tvar <= tv;
        itgt <= tv ? ~tgt : tgt;
        ivar <= tgt;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (done !== 1'b1 && n < 12);
        ivld <= 1'b0;
        dn = done;
    endtask : ins

    initial begin
        repeat (20) @(posedge core_clk_i);
        reset_i <= 1'b0;
        rd(`MSHBC_RAMP_OFS, 40'h00_0000_0100);
        rd(12'h020, 40'h01_0000_0000);
        apb(1'b1, `MSHBC_IDXVLD_OFS, 32'h0000_0007);
        apb(1'b1, `MSHBC_IDXSYN_OFS, 32'h0000_0004);
        apb(1'b1, `MSHBC_RAMP_OFS, 32'h0000_0004);
        tdone("registers");
        ins(MSHBC_OP_BLEND, 1'b0, 4'h0, 4'h1, 1'b0, ok);
        chk({ok, ck, diri, ramp_nx, ctgt}, {1'b1, MSHBC_CH_BLEND, 2'b10, 4'h1});
        ins(MSHBC_OP_BLEND, 1'b0, 4'h0, 4'h1, 1'b1, ok);
        chk({ck, ctgt}, {MSHBC_CH_BLEND, 4'h1});
        ins(MSHBC_OP_BLEND, 1'b0, 4'h0, 4'h5, 1'b0, ok);
        chk(ck, MSHBC_CH_CHAIN);
        ins(MSHBC_OP_BLEND, 1'b0, 4'h0, 4'h2, 1'b0, ok);
        chk(ck, MSHBC_CH_CHAIN);
        ins(MSHBC_OP_CHAIN, 1'b0, 4'h0, 4'h1, 1'b0, ok);
        chk({ck, ramp_nx}, {MSHBC_CH_CHAIN, 1'b1});
        tdone("blend");
        ins(MSHBC_OP_GEAR_ON, 1'b0, 4'h0, 4'h0, 1'b0, ok);
        chk({ok, gear}, 3'b101);
        ins(MSHBC_OP_GEAR_ON, 1'b0, 4'h0, 4'h0, 1'b0, ok);
        chk({ok, gear}, 3'b001);
        @(posedge core_clk_i);
        pend <= 1'b1;
        @(posedge core_clk_i);
        pend <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        chk(gear, 2'b00);
        ins(MSHBC_OP_GEAR_OFF, 1'b0, 4'h0, 4'h0, 1'b0, ok);
        chk(ok, 1'b1);
        tdone("gear");
        rnd = 4'($random(seed));
        ins(MSHBC_OP_INDEX, 1'b0, rnd, 4'h0, 1'b0, ok);
        chk({ok, sidx, sl}, {1'b1, rnd, 1'b0});
        ins(MSHBC_OP_GEAR_ON, 1'b1, 4'h0, 4'h0, 1'b0, ok);
        hold <= 1'b1;
        repeat (12) @(posedge core_clk_i);
        chk({rate, mip[0], mcr[0], gear[1]}, {32'h0, 3'b111});
        ins(MSHBC_OP_INDEX, 1'b0, 4'h3, 4'h0, 1'b0, ok);
        chk({ok, 8'(st_cnt)}, {1'b0, 8'h06});
        hold <= 1'b0;
        repeat (12) @(posedge core_clk_i);
        chk(rate, 32'h0004_0004);
        lhold <= 2'b10;
        repeat (12) @(posedge core_clk_i);
        chk(rate, 32'h0000_0004);
        lhold <= 2'b00;
        repeat (12) @(posedge core_clk_i);
        tdone("hold");
        ins(MSHBC_OP_LANE_STOP, 1'b1, 4'h0, 4'h0, 1'b0, ok);
        ins(MSHBC_OP_INDEX, 1'b1, 4'h2, 4'h0, 1'b0, ok);
        chk({hseen, ok, lblk}, 5'b10100);
        ins(MSHBC_OP_JOG_STOP, 1'b1, 4'h0, 4'h0, 1'b0, ok);
        repeat (2) @(posedge core_clk_i);
        chk(jseen, 2'b10);
        lmh <= 2'b01;
        repeat (5) @(posedge core_clk_i);
        ins(MSHBC_OP_INDEX, 1'b0, 4'h1, 4'h0, 1'b0, ok);
        chk({ok, lblk, kill}, 4'b0010);
        lmh <= 2'b00;
        halt <= 1'b1;
        hold <= 1'b1;
        repeat (5) @(posedge core_clk_i);
        ins(MSHBC_OP_GEAR_OFF, 1'b0, 4'h0, 4'h0, 1'b0, ok);
        chk({ok, lblk, kill, gear}, 6'b111000);
        stop <= 1'b1;
        repeat (5) @(posedge core_clk_i);
        chk({lblk, kill}, 3'b111);
        stop <= 1'b0;
        halt <= 1'b0;
        hold <= 1'b0;
        repeat (12) @(posedge core_clk_i);
        tdone("stops");
        ins(MSHBC_OP_STOP_ON, 1'b0, 4'h0, 4'h0, 1'b0, ok);
        repeat (3) @(posedge core_clk_i);
        chk({kill, lblk}, 3'b111);
        rd(`MSHBC_STAT_OFS, 40'h00_0000_0314);
        apb(1'b1, `MSHBC_CTRL_OFS, 32'h0000_0100);
        repeat (3) @(posedge core_clk_i);
        chk({kill, lblk}, 3'b000);
        ins(MSHBC_OP_HOLD_ON, 1'b0, 4'h0, 4'h0, 1'b0, ok);
        repeat (20) @(posedge core_clk_i);
        chk(rate, 32'h0);
        ins(MSHBC_OP_HOLD_OFF, 1'b0, 4'h0, 4'h0, 1'b0, ok);
        ins(MSHBC_OP_LHOLD_ON, 1'b0, 4'h0, 4'h0, 1'b0, ok);
        repeat (12) @(posedge core_clk_i);
        chk(rate, 32'h0004_0000);
        ins(MSHBC_OP_LHOLD_OFF, 1'b0, 4'h0, 4'h0, 1'b0, ok);
        repeat (12) @(posedge core_clk_i);
        chk(rate, 32'h0004_0004);
        apb(1'b1, `MSHBC_CTRL_OFS, 32'h0000_0002);
        repeat (3) @(posedge core_clk_i);
        chk({kill, lblk}, 3'b011);
        apb(1'b1, `MSHBC_CTRL_OFS, 32'h0000_0000);
        tdone("program");
        conclude();
    end
endmodule : tb_top
`default_nettype wire
